// *** design/ufl_pkg.sv ***
// Shared constants for the flow-controlled UART: register map, field
// positions, reset values and low-speed rate table.
// Assumes a 32-bit AHB-Lite register bus and a single sys_clk domain.
package ufl_pkg;

	// ---------------------------------------------------------------
	// Register offsets (byte addresses)
	// ---------------------------------------------------------------
	localparam logic [4:0] OFS_CTRL  = 5'h00;
	localparam logic [4:0] OFS_BAUD  = 5'h04;
	localparam logic [4:0] OFS_TXDAT = 5'h08;
	localparam logic [4:0] OFS_RXDAT = 5'h0c;
	localparam logic [4:0] OFS_FLAGS = 5'h10;
	localparam logic [4:0] OFS_IRQEN = 5'h14;
	localparam logic [4:0] OFS_FCLR  = 5'h18;

	// ---------------------------------------------------------------
	// Control register fields
	// ---------------------------------------------------------------
	localparam int CTL_TX_EN    = 0;
	localparam int CTL_RX_EN    = 1;
	localparam int CTL_SEND_GT  = 2;
	localparam int CTL_REQ_GT   = 3;
	localparam int CTL_START_LV = 4;
	localparam int CTL_SYNC     = 5;
	localparam int CTL_LS_SRC   = 6;
	localparam int CTL_PAR_EN   = 7;
	localparam int CTL_RATE_LO  = 8;
	localparam int CTL_W        = 10;
	localparam logic [CTL_W-1:0] CTL_RESET = 10'h000;

	// ---------------------------------------------------------------
	// Flag register fields (status, enable and clear share them)
	// ---------------------------------------------------------------
	localparam int FL_TXE   = 0;
	localparam int FL_TC    = 1;
	localparam int FL_RC    = 2;
	localparam int FL_FE    = 3;
	localparam int FL_PE    = 4;
	localparam int FL_CTS   = 5;
	localparam int FL_N     = 6;
	localparam int ST_SEND_GATE_LEVEL = 6;
	localparam int ST_BUSY  = 7;
	localparam logic [FL_N-1:0] FL_RESET = 6'h01;

	localparam logic [15:0] BAUD_RESET = 16'h0364;

	// ---------------------------------------------------------------
	// Low-speed transfer rates (bits per second)
	// ---------------------------------------------------------------
	localparam int RATE_2400 = 2400;
	localparam int RATE_4800 = 4800;
	localparam int RATE_9600 = 9600;

	localparam int CTS_SYNC_STAGES = 2;

	// Last tick of a bit period; a length of zero behaves as one
	function automatic logic bitEnd(input logic [15:0] cnt, input logic [15:0] len);
		bitEnd = ({1'b0, cnt} + 17'h00001) >= {1'b0, len};
	endfunction : bitEnd

endpackage : ufl_pkg

// *** design/ufl_rx.sv ***
// Frame receiver matching ufl_tx framing. Start is taken on a falling edge
// or, when levelStart is set, on any low level of rxd.
`timescale 1ns/1ps
`default_nettype none

module ufl_rx
	import ufl_pkg::*;
(
	// Clock and reset
	input  wire logic        sys_clk,
	input  wire logic        rstn,
	// Control
	input  wire logic        enable,
	input  wire logic        tick,
	input  wire logic [15:0] bitLen,
	input  wire logic        parEn,
	input  wire logic        levelStart,
	input  wire logic        rxd,
	// Received frame
	output logic             valid,
	output logic [7:0]       data,
	output logic             frameErr,
	output logic             parErr
);

	typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP} ufl_rx_e;

	ufl_rx_e     state_q;
	logic [15:0] cnt_q;
	logic [2:0]  idx_q;
	logic [7:0]  shift_q;
	logic        parBad_q;
	logic        rxPrev_q;
	logic        startSeen;

	// Level start also catches a line already low when enabled
	assign startSeen = levelStart ? !rxd : (rxPrev_q && !rxd);

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			rxPrev_q <= 1'b1;
		end else if (tick) begin
			rxPrev_q <= rxd;
		end
	end

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			state_q  <= RX_IDLE;
			cnt_q    <= 16'h0000;
			idx_q    <= 3'h0;
			shift_q  <= 8'h00;
			parBad_q <= 1'b0;
			valid    <= 1'b0;
			data     <= 8'h00;
			frameErr <= 1'b0;
			parErr   <= 1'b0;
		end else begin
			valid <= 1'b0;
			if (!enable) begin
				state_q <= RX_IDLE;
			end else if (tick) begin
				unique case (state_q)
					RX_IDLE: begin
						if (startSeen) begin
							cnt_q    <= 16'h0000;
							parBad_q <= 1'b0;
							state_q  <= RX_START;
						end
					end
					RX_START: begin
						// Detection already cost a tick, so this lands near mid-bit
						if (bitEnd(cnt_q, {1'b0, bitLen[15:1]})) begin
							cnt_q   <= 16'h0000;
							idx_q   <= 3'h0;
							state_q <= rxd ? RX_IDLE : RX_DATA;
						end else begin
							cnt_q <= cnt_q + 16'h0001;
						end
					end
					default: begin
						if (!bitEnd(cnt_q, bitLen)) begin
							cnt_q <= cnt_q + 16'h0001;
						end else begin
							cnt_q <= 16'h0000;
							if (state_q == RX_DATA) begin
								shift_q <= {rxd, shift_q[7:1]};
								idx_q   <= idx_q + 3'h1;
								if (idx_q == 3'h7) begin
									state_q <= parEn ? RX_PAR : RX_STOP;
								end
							end else if (state_q == RX_PAR) begin
								parBad_q <= (^shift_q) ^ rxd;
								state_q  <= RX_STOP;
							end else begin
								valid    <= 1'b1;
								data     <= shift_q;
								frameErr <= !rxd;
								parErr   <= parBad_q;
								state_q  <= RX_IDLE;
							end
						end
					end
				endcase
			end
		end
	end

endmodule : ufl_rx

`default_nettype wire

// *** design/ufl_top.sv ***
// UART core with send/request gating, six-source interrupt and low-power
// transfer clock selection, behind an AHB-Lite slave.
// Assumes one sys_clk; lsTick is a one-cycle pulse per low-speed clock period.
`timescale 1ns/1ps
`default_nettype none

module ufl_top
	import ufl_pkg::*;
#(
	parameter int LS_CLK_HZ = 32768
) (
	// Clock and reset
	input  wire logic        sys_clk,
	input  wire logic        rstn,
	// AHB-Lite slave
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic [31:0]      hrdata,
	output logic             hreadyout,
	output logic             hresp,
	// Power and transfer clock
	input  wire logic        deepSleep,
	input  wire logic        lsTick,
	// Serial line and handshake
	input  wire logic        rxd,
	output logic             txd,
	input  wire logic        ctsN,
	output logic             rtsN_q,
	// Interrupt
	output logic             irq_q
);

	// ---------------------------------------------------------------
	// Declarations
	// ---------------------------------------------------------------
	localparam logic [15:0] LS_DIV_2400 = 16'(LS_CLK_HZ / RATE_2400);
	localparam logic [15:0] LS_DIV_4800 = 16'(LS_CLK_HZ / RATE_4800);
	localparam logic [15:0] LS_DIV_9600 = 16'(LS_CLK_HZ / RATE_9600);

	logic [CTL_W-1:0] ctrl_q;
	logic [15:0]      baud_q;
	logic [7:0]       tdr_q;
	logic [7:0]       rdr_q;
	logic [FL_N-1:0]  isr_q, isr_d, ier_q, flSet, flClr;
	logic             wrPend_q;
	logic [4:0]       wrAddr_q;
	logic [CTS_SYNC_STAGES-1:0] ctsSync_q;
	logic             ctsPrev_q;
	logic             addrOk, wrTdr, wrIcr, tick;
	logic [15:0]      bitLen;
	logic             txBusy, txDone, txLoad, txOk, ctsHigh;
	logic             rxValid, rxFe, rxPe;
	logic [7:0]       rxData;

	// ---------------------------------------------------------------
	// AHB-Lite slave, zero wait states, always OKAY
	// ---------------------------------------------------------------
	assign addrOk = hsel && htrans[1] && hready;

	function automatic logic [31:0] readMux(input logic [4:0] a);
		unique case (a)
			OFS_CTRL:  readMux = {22'h000000, ctrl_q};
			OFS_BAUD:  readMux = {16'h0000, baud_q};
			OFS_TXDAT: readMux = {24'h000000, tdr_q};
			OFS_RXDAT: readMux = {24'h000000, rdr_q};
			OFS_FLAGS: readMux = {24'h000000, txBusy, ctsHigh, isr_q};
			OFS_IRQEN: readMux = {26'h0000000, ier_q};
			default:   readMux = 32'h00000000;
		endcase
	endfunction : readMux

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			wrPend_q  <= 1'b0;
			wrAddr_q  <= 5'h00;
			hrdata    <= 32'h00000000;
			hreadyout <= 1'b0;
			hresp     <= 1'b0;
		end else begin
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
			wrPend_q  <= addrOk && hwrite;
			if (addrOk) begin
				wrAddr_q <= (haddr[31:5] == 27'h0000000) ? haddr[4:0] : 5'h1f;
			end
			if (addrOk && !hwrite) begin
				hrdata <= (haddr[31:5] == 27'h0000000) ? readMux(haddr[4:0]) : 32'h00000000;
			end
		end
	end

	assign wrTdr = wrPend_q && (wrAddr_q == OFS_TXDAT);
	assign wrIcr = wrPend_q && (wrAddr_q == OFS_FCLR);

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			ctrl_q <= CTL_RESET;
			baud_q <= BAUD_RESET;
			ier_q  <= '0;
			tdr_q  <= 8'h00;
		end else if (wrPend_q) begin
			unique case (wrAddr_q)
				OFS_CTRL:  ctrl_q <= hwdata[CTL_W-1:0];
				OFS_BAUD:  baud_q <= hwdata[15:0];
				OFS_IRQEN: ier_q  <= hwdata[FL_N-1:0];
				OFS_TXDAT: tdr_q  <= hwdata[7:0];
				default:   ;
			endcase
		end
	end

	// ---------------------------------------------------------------
	// Gate input synchroniser and change detect
	// ---------------------------------------------------------------
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			ctsSync_q <= '1;
			ctsPrev_q <= 1'b1;
		end else begin
			ctsSync_q <= {ctsSync_q[0], ctsN};
			ctsPrev_q <= ctsSync_q[1];
		end
	end

	assign ctsHigh = ctsSync_q[1];

	// ---------------------------------------------------------------
	// Transfer clock select
	// ---------------------------------------------------------------
	// High-speed source is the system clock, which stops in deep sleep
	assign tick = ctrl_q[CTL_LS_SRC] ? lsTick : !deepSleep;

	// Low-speed source only offers three rates, each divisor truncated to whole ticks
	always_comb begin
		if (!ctrl_q[CTL_LS_SRC]) begin
			bitLen = baud_q;
		end else begin
			unique case (ctrl_q[CTL_RATE_LO +: 2])
				2'h0:    bitLen = LS_DIV_2400;
				2'h1:    bitLen = LS_DIV_4800;
				default: bitLen = LS_DIV_9600;
			endcase
		end
	end

	// ---------------------------------------------------------------
	// Transmit path
	// ---------------------------------------------------------------
	// Busy covers the whole frame, so a gate change mid-frame only holds the next
	assign txOk   = ctrl_q[CTL_TX_EN] && !ctrl_q[CTL_SYNC];
	assign txLoad = txOk && !isr_q[FL_TXE] && !txBusy
	                && (!ctrl_q[CTL_SEND_GT] || !ctsHigh);

	ufl_tx u_tx (
		.sys_clk (sys_clk),
		.rstn    (rstn),
		.tick    (tick),
		.bitLen  (bitLen),
		.parEn   (ctrl_q[CTL_PAR_EN]),
		.start   (txLoad),
		.data    (tdr_q),
		.busy    (txBusy),
		.done    (txDone),
		.txd     (txd)
	);

	// ---------------------------------------------------------------
	// Receive path
	// ---------------------------------------------------------------
	ufl_rx u_rx (
		.sys_clk    (sys_clk),
		.rstn       (rstn),
		.enable     (ctrl_q[CTL_RX_EN] && !ctrl_q[CTL_SYNC]),
		.tick       (tick),
		.bitLen     (bitLen),
		.parEn      (ctrl_q[CTL_PAR_EN]),
		.levelStart (ctrl_q[CTL_START_LV]),
		.rxd        (rxd),
		.valid      (rxValid),
		.data       (rxData),
		.frameErr   (rxFe),
		.parErr     (rxPe)
	);

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			rdr_q <= 8'h00;
		end else if (rxValid) begin
			rdr_q <= rxData;
		end
	end

	// ---------------------------------------------------------------
	// Flags, enables and interrupt
	// ---------------------------------------------------------------
	always_comb begin
		flSet         = '0;
		flSet[FL_TXE] = txLoad;
		flSet[FL_TC]  = txDone;
		flSet[FL_RC]  = rxValid;
		flSet[FL_FE]  = rxValid && rxFe;
		flSet[FL_PE]  = rxValid && rxPe;
		flSet[FL_CTS] = ctsHigh != ctsPrev_q;
		flClr         = wrIcr ? ~hwdata[FL_N-1:0] : '0;
		flClr[FL_TXE] = wrTdr;
		isr_d         = (isr_q & ~flClr) | flSet;
		// A data write landing with a load refills the buffer, so it wins here
		isr_d[FL_TXE] = (isr_q[FL_TXE] || txLoad) && !wrTdr;
	end

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			isr_q <= FL_RESET;
		end else begin
			isr_q <= isr_d;
		end
	end

	// One line for all sources; rx done enabled also serves as wake-up
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			irq_q <= 1'b0;
		end else begin
			irq_q <= |(isr_q & ier_q);
		end
	end

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			rtsN_q <= 1'b0;
		end else begin
			rtsN_q <= ctrl_q[CTL_REQ_GT] && isr_q[FL_RC];
		end
	end

	// ---------------------------------------------------------------
	// Assertions
	// ---------------------------------------------------------------
	sequence sGateClosed;
		ctrl_q[CTL_SEND_GT] && ctsHigh;
	endsequence

	sequence sFrameStart;
		$rose(txBusy);
	endsequence

	a_gate_blocks_start: assert property (@(posedge sys_clk) disable iff (!rstn)
		sGateClosed ##1 sFrameStart |-> 1'b0)
		else $error("frame started while send gate was closed");

	a_start_needs_data: assert property (@(posedge sys_clk) disable iff (!rstn)
		sFrameStart |-> $past(ctrl_q[CTL_TX_EN]) && !$past(isr_q[FL_TXE]) && isr_q[FL_TXE])
		else $error("frame started without enable or buffered data");

	a_level_two_stage: assert property (@(posedge sys_clk) disable iff (!rstn)
		##2 ctsHigh == $past(ctsN, 2))
		else $error("gate level status not two stages behind input");

	a_change_sets_flag: assert property (@(posedge sys_clk) disable iff (!rstn)
		$changed(ctsHigh) |=> isr_q[FL_CTS])
		else $error("gate change did not set change flag");

	a_clear_on_zero: assert property (@(posedge sys_clk) disable iff (!rstn)
		wrIcr && !hwdata[FL_CTS] && ctsHigh == ctsPrev_q |=> !isr_q[FL_CTS])
		else $error("change flag not cleared by write of zero");

	a_keep_on_one: assert property (@(posedge sys_clk) disable iff (!rstn)
		wrIcr && hwdata[FL_CTS] && isr_q[FL_CTS] |=> isr_q[FL_CTS])
		else $error("change flag lost on write of one");

	a_txe_by_write: assert property (@(posedge sys_clk) disable iff (!rstn)
		wrTdr |=> !isr_q[FL_TXE])
		else $error("buffer empty flag not cleared by data write");

	a_irq_or_flags: assert property (@(posedge sys_clk) disable iff (!rstn)
		##1 irq_q == |($past(isr_q) & $past(ier_q)))
		else $error("interrupt line does not follow enabled flags");

	a_done_sets_tc: assert property (@(posedge sys_clk) disable iff (!rstn)
		txDone |=> isr_q[FL_TC] ##1 (irq_q || !ier_q[FL_TC]))
		else $error("sent frame did not set tx done");

	a_rx_sets_rc: assert property (@(posedge sys_clk) disable iff (!rstn)
		rxValid |=> isr_q[FL_RC] && rdr_q == $past(rxData))
		else $error("received frame not flagged or stored");

	a_rts_follows_rc: assert property (@(posedge sys_clk) disable iff (!rstn)
		##1 rtsN_q == ($past(ctrl_q[CTL_REQ_GT]) && $past(isr_q[FL_RC])))
		else $error("request output does not follow rx done");

	a_hs_sleep_halt: assert property (@(posedge sys_clk) disable iff (!rstn)
		deepSleep && !ctrl_q[CTL_LS_SRC] && txBusy |=> $stable(txd))
		else $error("transfer moved while high-speed source stopped");

	a_sync_no_tx: assert property (@(posedge sys_clk) disable iff (!rstn)
		ctrl_q[CTL_SYNC] && !txBusy |=> !txBusy)
		else $error("transmit started with sync select set");

endmodule : ufl_top

`default_nettype wire

// *** design/ufl_tx.sv ***
// Frame transmitter: start bit, eight data bits LSB first, optional even
// parity, one stop bit. Assumes tick marks one transfer clock period.
`timescale 1ns/1ps
`default_nettype none

module ufl_tx
	import ufl_pkg::*;
(
	// Clock and reset
	input  wire logic        sys_clk,
	input  wire logic        rstn,
	// Control
	input  wire logic        tick,
	input  wire logic [15:0] bitLen,
	input  wire logic        parEn,
	input  wire logic        start,
	input  wire logic [7:0]  data,
	// Status and line
	output logic             busy,
	output logic             done,
	output logic             txd
);

	typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP} ufl_tx_e;

	ufl_tx_e     state_q;
	logic [15:0] cnt_q;
	logic [2:0]  idx_q;
	logic [7:0]  shift_q;
	logic        par_q;

	assign busy = (state_q != TX_IDLE);

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			state_q <= TX_IDLE;
			cnt_q   <= 16'h0000;
			idx_q   <= 3'h0;
			shift_q <= 8'h00;
			par_q   <= 1'b0;
			txd     <= 1'b1;
			done    <= 1'b0;
		end else begin
			done <= 1'b0;
			if (state_q == TX_IDLE) begin
				if (start) begin
					shift_q <= data;
					par_q   <= ^data;
					cnt_q   <= 16'h0000;
					txd     <= 1'b0;
					state_q <= TX_START;
				end
			end else if (tick) begin
				if (!bitEnd(cnt_q, bitLen)) begin
					cnt_q <= cnt_q + 16'h0001;
				end else begin
					cnt_q <= 16'h0000;
					unique case (state_q)
						TX_START: begin
							txd     <= shift_q[0];
							idx_q   <= 3'h0;
							state_q <= TX_DATA;
						end
						TX_DATA: begin
							if (idx_q == 3'h7) begin
								txd     <= parEn ? par_q : 1'b1;
								state_q <= parEn ? TX_PAR : TX_STOP;
							end else begin
								txd     <= shift_q[1];
								shift_q <= {1'b0, shift_q[7:1]};
								idx_q   <= idx_q + 3'h1;
							end
						end
						TX_PAR: begin
							txd     <= 1'b1;
							state_q <= TX_STOP;
						end
						TX_STOP: begin
							done    <= 1'b1;
							state_q <= TX_IDLE;
						end
						default: state_q <= TX_IDLE;
					endcase
				end
			end
		end
	end

endmodule : ufl_tx

`default_nettype wire

// *** dv/uart_flow_irq_lowpower_tb.sv ***
// Self-checking bench: AHB-Lite master, gated transmit, flags, interrupt,
// receive with request gating. Assumes ufl_top with BAUD set to 4.
`timescale 1ns/1ps
`default_nettype none

module uart_flow_irq_lowpower_tb
	import ufl_pkg::*;
;
	localparam int LS_HZ = 32768;
	logic        sys_clk, rstn, hsel, hwrite, deepSleep, lsTick, hold;
	logic [1:0]  htrans;
	logic [2:0]  hsize;
	logic [31:0] haddr, hwdata, hrdata, rd;
	logic        hreadyout, hresp, rxd, txd, ctsN, rtsN_q, irq_q;
	logic [7:0]  a, b, bitCyc;
	int          n_fail = 0, checked = 0, cycles = 0, seed = 32'h0f330784;

	ufl_top #(.LS_CLK_HZ(LS_HZ)) ufl_top_i (.sys_clk(sys_clk), .rstn(rstn), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
		.deepSleep(deepSleep), .lsTick(lsTick), .rxd(rxd), .txd(txd), .ctsN(ctsN),
		.rtsN_q(rtsN_q), .irq_q(irq_q));
	ufl_peer ufl_peer_i (.sys_clk(sys_clk), .bitCyc(bitCyc), .txd(txd), .rtsN_q(rtsN_q),
		.hold(hold), .ctsN(ctsN), .rxd(rxd));

	// ---------------------------------------------------------------
	// Clock, timeout and shared tasks
	// ---------------------------------------------------------------
	initial begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end

	always @(posedge sys_clk) begin
		// Low-speed tick: one-cycle pulse every second cycle
		lsTick <= cycles[0];
		cycles++;
		if (cycles == 30000) begin
			n_fail++;
			test_done();
		end
	end

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			n_fail++;
			$display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk

	// Line cycles per bit for a low-speed rate, two cycles per tick
	function automatic logic [7:0] lsBit(input int r);
		lsBit = 8'(2 * (LS_HZ / r));
	endfunction : lsBit

	task automatic bus(input logic w, input logic [31:0] ad, input logic [31:0] d);
		hsel <= 1'b1;
		haddr <= ad;
		hwrite <= w;
		htrans <= 2'b10;
		do @(posedge sys_clk); while (hreadyout !== 1'b1);
		htrans <= 2'b00;
		hwdata <= d;
		do @(posedge sys_clk); while (hreadyout !== 1'b1);
		rd = hrdata;
	endtask : bus

	task automatic rdchk(input logic [31:0] ad, input logic [31:0] exp);
		bus(1'b0, ad, 32'h0);
		chk(rd, exp);
		chk(32'(hresp), 32'h0);
	endtask : rdchk

	task automatic test_done;
		$display("comparisons %0d, mismatches %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : test_done

	// ---------------------------------------------------------------
	// Main sequence
	// ---------------------------------------------------------------
	initial begin
		{rstn, hsel, hwrite, deepSleep} = 4'h0;
		{htrans, haddr, hwdata} = '0;
		hsize = 3'b010;
		hold = 1'b1;
		bitCyc = 8'h04;
		repeat (16) @(posedge sys_clk);
		rstn <= 1'b1;
		repeat (2) @(posedge sys_clk);
		rdchk(32'(OFS_FLAGS), 32'h41);
		rdchk(32'(OFS_BAUD), 32'h364);
		rdchk(32'h40, 32'h0);
		chk(32'(irq_q), 32'h0);
		bus(1'b1, 32'(OFS_BAUD), 32'h4);
		bus(1'b1, 32'(OFS_IRQEN), 32'h22);
		bus(1'b1, 32'(OFS_CTRL), 32'h0f);
		a = 8'($random(seed));
		b = 8'($random(seed));
		// Gate closed: byte must wait in the buffer
		bus(1'b1, 32'(OFS_TXDAT), {24'h0, a});
		repeat (200) @(posedge sys_clk);
		chk(32'(ufl_peer_i.frames), 32'h0);
		rdchk(32'(OFS_FLAGS), 32'h40);
		hold <= 1'b0;
		while (txd !== 1'b0) @(posedge sys_clk);
		hold <= 1'b1;
		bus(1'b1, 32'(OFS_TXDAT), {24'h0, b});
		while (ufl_peer_i.frames < 1) @(posedge sys_clk);
		chk(32'(ufl_peer_i.got), 32'(a));
		repeat (200) @(posedge sys_clk);
		chk(32'(ufl_peer_i.frames), 32'h1);
		rdchk(32'(OFS_FLAGS), 32'h62);
		chk(32'(irq_q), 32'h1);
		bus(1'b1, 32'(OFS_FCLR), 32'h1f);
		rdchk(32'(OFS_FLAGS), 32'h42);
		chk(32'(irq_q), 32'h1);
		bus(1'b1, 32'(OFS_FCLR), 32'h3d);
		rdchk(32'(OFS_FLAGS), 32'h40);
		chk(32'(irq_q), 32'h0);
		hold <= 1'b0;
		while (ufl_peer_i.frames < 2) @(posedge sys_clk);
		chk(32'(ufl_peer_i.got), 32'(b));
		repeat (20) @(posedge sys_clk);
		rdchk(32'(OFS_FLAGS), 32'h23);
		// Receive path, edge then level start detection
		bus(1'b1, 32'(OFS_FCLR), 32'h0);
		bus(1'b1, 32'(OFS_IRQEN), 32'h4);
		for (int i = 0; i < 4; i++) begin
			a = 8'($random(seed));
			bus(1'b1, 32'(OFS_CTRL), 32'({i[0], 4'hf}));
			ufl_peer_i.sendFrame(a);
			repeat (8) @(posedge sys_clk);
			chk(32'(rtsN_q), 32'h1);
			chk(32'(irq_q), 32'h1);
			rdchk(32'(OFS_RXDAT), 32'(a));
			bus(1'b1, 32'(OFS_FCLR), 32'h3b);
			repeat (2) @(posedge sys_clk);
			chk(32'(rtsN_q), 32'h0);
			chk(32'(irq_q), 32'h0);
		end
		// Low-speed source keeps both directions alive in deep sleep
		deepSleep <= 1'b1;
		for (int i = 0; i < 3; i++) begin
			bitCyc <= lsBit(RATE_2400 << i);
			bus(1'b1, 32'(OFS_CTRL), 32'h43 | (32'(i) << CTL_RATE_LO));
			a = 8'($random(seed));
			b = 8'($random(seed));
			bus(1'b1, 32'(OFS_TXDAT), {24'h0, a});
			while (ufl_peer_i.frames < 3 + i) @(posedge sys_clk);
			chk(32'(ufl_peer_i.got), 32'(a));
			ufl_peer_i.sendFrame(b);
			repeat (4) @(posedge sys_clk);
			chk(32'(irq_q), 32'h1);
			rdchk(32'(OFS_RXDAT), 32'(b));
			bus(1'b1, 32'(OFS_FCLR), 32'h3b);
		end
		// High-speed source stops in deep sleep: no receive, transmit frozen
		bitCyc <= 8'h04;
		bus(1'b1, 32'(OFS_CTRL), 32'h03);
		ufl_peer_i.sendFrame(a);
		repeat (8) @(posedge sys_clk);
		chk(32'(irq_q), 32'h0);
		rdchk(32'(OFS_RXDAT), 32'(b));
		bus(1'b1, 32'(OFS_FCLR), 32'h3d);
		bus(1'b1, 32'(OFS_TXDAT), {24'h0, b});
		repeat (40) @(posedge sys_clk);
		chk(32'(txd), 32'h0);
		deepSleep <= 1'b0;
		repeat (60) @(posedge sys_clk);
		rdchk(32'(OFS_FLAGS), 32'h03);
		test_done();
	end
endmodule : uart_flow_irq_lowpower_tb

`default_nettype wire

// *** dv/ufl_peer.sv ***
// Serial peer model: holds the send-gate line, sends and decodes 8N1 frames.
// Assumes sys_clk times the bits, bitCyc cycles per bit, parity off.
`timescale 1ns/1ps
`default_nettype none

module ufl_peer (
	// Clock and bit time in clock cycles
	input  wire logic       sys_clk,
	input  wire logic [7:0] bitCyc,
	// Line and handshake
	input  wire logic       txd,
	input  wire logic       rtsN_q,
	input  wire logic       hold,
	output logic            ctsN,
	output var logic        rxd
);
	// ---------------------------------------------------------------
	// Gate line and frame decode
	// ---------------------------------------------------------------
	int         frames = 0;
	logic [7:0] got;

	assign ctsN = hold; // Bench decides when the peer stops us
	initial rxd = 1'b1;

	always begin
		@(negedge txd);
		repeat (bitCyc + bitCyc / 2) @(posedge sys_clk);
		for (int i = 0; i < 8; i++) begin
			got[i] = txd;
			repeat (bitCyc) @(posedge sys_clk);
		end
		frames++;
	end

	// Waits while the device asks us to pause
	task automatic sendFrame(input logic [7:0] b);
		logic [9:0] f;
		f = {1'b1, b, 1'b0};
		while (rtsN_q !== 1'b0) @(posedge sys_clk);
		for (int i = 0; i < 10; i++) begin
			rxd <= f[i];
			repeat (bitCyc) @(posedge sys_clk);
		end
	endtask : sendFrame
endmodule : ufl_peer

`default_nettype wire
